//--- spdref_checker.sv
// Concurrent checks on the speed reference block ports
`timescale 1ns/1ps
`include "spdref_defines.svh"
module spdref_checker
  import spdref_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        drive_enable,
  input wire logic        remote_mode,
  input wire logic        local_direction_select,
  input wire logic        remote_direction_select,
  input wire logic        fault_reset,
  input wire logic [15:0] motor_rated_speed_setting,
  input wire logic [15:0] actual_speed,
  input wire logic        dc_undervoltage,
  input wire logic [15:0] speed_reference,
  input wire logic        reverse_dir,
  input wire logic        jog_active,
  input wire logic        pwm_block,
  input wire logic        overspeed_fault,
  input wire logic [7:0]  overspeed_fault_code,
  input wire logic        nv_write
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_idle;
    (!drive_enable && !jog_active) [*3];
  endsequence
  sequence s_tripped;
    overspeed_fault [*2];
  endsequence
  sequence s_dir_steady;
    jog_active && $stable(remote_mode) && $stable(local_direction_select)
      && $stable(remote_direction_select);
  endsequence

  fault_code_a: assert property (overspeed_fault_code == (overspeed_fault ? `SPDREF_FAULT_CODE : 8'h00))
    else $error("fault code does not follow fault");
  fault_pwm_a: assert property (overspeed_fault |-> pwm_block)
    else $error("pulses not blocked on fault");
  fault_hold_a: assert property (overspeed_fault && !fault_reset |=> overspeed_fault)
    else $error("fault dropped without reset");
  fault_zero_a: assert property (s_tripped |-> speed_reference == 16'h0000)
    else $error("reference not zero while faulted");
  idle_zero_a: assert property (s_idle |-> speed_reference == 16'h0000)
    else $error("reference not zero while disabled");
  nv_pulse_a: assert property (nv_write |=> !nv_write)
    else $error("save strobe longer than one cycle");
  nv_cause_a: assert property (nv_write |-> $past(dc_undervoltage) || $past(dc_undervoltage, 2))
    else $error("save without undervoltage");
  ref_limit_a: assert property (speed_reference <= `SPDREF_SPEED_MAX)
    else $error("reference above speed range");
  ref_rated_a: assert property ($stable(motor_rated_speed_setting) |->
    24'(speed_reference) * 24'd10 <= 24'(motor_rated_speed_setting) * 24'd34)
    else $error("reference above rated cap");
  jog_stop_a: assert property ($rose(jog_active) |-> $past(actual_speed) == 16'h0000)
    else $error("jog entered while turning");
  jog_dir_a: assert property (s_dir_steady |->
    reverse_dir == (remote_mode ? remote_direction_select : local_direction_select))
    else $error("jog direction wrong");
endmodule : spdref_checker

bind spdref_top spdref_checker u_spdref_checker (.*);

//--- spdref_defines.svh
// Constants for the speed reference, jog and limit block
`ifndef SPDREF_DEFINES_SVH
`define SPDREF_DEFINES_SVH

// ****
// Parameter indices
// ****
`define SPDREF_IDX_BACKUP    10'h078
`define SPDREF_IDX_KEYPAD    10'h079
`define SPDREF_IDX_JOGP      10'h07A
`define SPDREF_IDX_JOGM      10'h07B
`define SPDREF_IDX_MARGIN    10'h084
`define SPDREF_IDX_MIN       10'h085
`define SPDREF_IDX_MAX       10'h086
`define SPDREF_IDX_STATUS    10'h0C8
`define SPDREF_IDX_REF_OUT   10'h0C9

// ****
// Reset values
// ****
`define SPDREF_RST_BACKUP    16'h0001
`define SPDREF_RST_KEYPAD    16'h005A
`define SPDREF_RST_JOGP      16'h0096
`define SPDREF_RST_JOGM      16'h0096
`define SPDREF_RST_MARGIN    16'h000A
`define SPDREF_RST_MIN       16'h005A
`define SPDREF_RST_MAX       16'h0708

// ****
// Codes, fields and limits
// ****
`define SPDREF_SRC_KEYPAD    4'h0
`define SPDREF_INCH_SRC_DIN  4'h1
`define SPDREF_FN_JOG        5'h0A
`define SPDREF_FN_JOGP       5'h10
`define SPDREF_FN_JOGM       5'h11
`define SPDREF_MARGIN_OFF    16'h0064
`define SPDREF_SPEED_MAX     16'h4650
`define SPDREF_CAP_NUM       6'h22
`define SPDREF_CAP_DEN       6'h0A
`define SPDREF_FAULT_CODE    8'h96

// ****
// Timing
// ****
`define SPDREF_CLK_HZ        40000000
`define SPDREF_OVS_TIME_MS   20

`endif

//--- spdref_ovs.sv
// Overspeed persistence monitor
`timescale 1ns/1ps
module spdref_ovs
  import spdref_pkg::*;
#(
  parameter int OVS_CYCLES = 800000
)(
  input  wire logic  sys_clk,
  input  wire logic  rstn,
  spdref_ovs_if.mon  ovs
);

  localparam int CW = $clog2(OVS_CYCLES + 2);

  logic [CW-1:0] count;
  logic          over;
  logic          elapsed;

  // ***********************************************
  // Persistence timer
  // ***********************************************
  assign over    = ovs.detect_en && ({2'b00, ovs.actual_speed} > ovs.threshold);
  assign elapsed = count > CW'(OVS_CYCLES);

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      count <= '0;
    else if (!over)
      count <= '0;
    else if (!elapsed)
      count <= count + CW'(1);
  end

  assign ovs.over_trip = over && elapsed;

endmodule : spdref_ovs

//--- spdref_ovs_if.sv
// Carrier between the reference logic and the overspeed monitor
`timescale 1ns/1ps
interface spdref_ovs_if;
  logic [17:0] threshold;
  logic        detect_en;
  logic [15:0] actual_speed;
  logic        over_trip;

  modport ctrl (output threshold, output detect_en, output actual_speed, input over_trip);
  modport mon  (input threshold, input detect_en, input actual_speed, output over_trip);
endinterface : spdref_ovs_if

//--- spdref_partner.sv
// Model of keypad keys, isolated inputs and speed feedback
`timescale 1ns/1ps
module spdref_partner (
  input  wire logic        sys_clk,
  input  wire logic [15:0] set_speed,
  input  wire logic [7:0]  din_req,
  input  wire logic        key_up_req,
  input  wire logic        key_dn_req,
  output logic      [15:0] actual_speed,
  output logic      [7:0]  isolated_digital_input,
  output logic             keypad_up,
  output logic             keypad_down
);
  initial
  begin
    actual_speed = 16'h0000;
    isolated_digital_input = 8'h00;
    keypad_up = 1'b0;
    keypad_down = 1'b0;
  end
  always @(posedge sys_clk)
  begin
    actual_speed <= set_speed;
    keypad_up    <= key_up_req;
    keypad_down  <= key_dn_req;
  end
  // Pins are asynchronous, so they move off the clock edge
  always @(din_req) isolated_digital_input = #7 din_req;
endmodule : spdref_partner

//--- spdref_pkg.sv
// Types for the speed reference, jog and limit block
package spdref_pkg;

  typedef enum logic [1:0] {
    SPDREF_IDLE,
    SPDREF_RUN,
    SPDREF_JOG
  } spdref_state_t;

  typedef logic [15:0] spdref_speed_t;

endpackage : spdref_pkg

//--- spdref_tb.sv
// Self-checking testbench for the speed reference block
`timescale 1ns/1ps
`include "spdref_defines.svh"
module testbench
  import spdref_pkg::*;
;
  logic sys_clk, rstn, par_wr, drive_enable, remote_mode, local_direction_select;
  logic remote_direction_select, inch_command, keypad_up, keypad_down, ext_reference_valid;
  logic dc_undervoltage, nv_restore_valid, fault_reset, reverse_dir, jog_active, pwm_block;
  logic overspeed_fault, nv_write, key_up_req, key_dn_req;
  logic [9:0] par_index;
  logic [3:0] local_reference_source_select, remote_reference_source_select;
  logic [3:0] local_inch_source_select, remote_inch_source_select;
  logic [7:0][4:0] input_function_select;
  logic [7:0] isolated_digital_input, din_req, overspeed_fault_code;
  logic [15:0] par_wdata, par_rdata, ext_reference, motor_rated_speed_setting, actual_speed;
  logic [15:0] nv_restore_data, speed_reference, nv_wdata, set_speed;
  int n_mismatch, samples_checked, cycles, kp, mn, mx, k, ex;
  localparam logic [9:0] RI [8] = '{`SPDREF_IDX_BACKUP, `SPDREF_IDX_KEYPAD, `SPDREF_IDX_JOGP,
    `SPDREF_IDX_JOGM, `SPDREF_IDX_MARGIN, `SPDREF_IDX_MIN, `SPDREF_IDX_MAX, 10'h3FF};
  localparam logic [15:0] RV [8] = '{16'h0001, 16'h005A, 16'h0096, 16'h0096, 16'h000A,
    16'h005A, 16'h0708, 16'h0000};
  localparam logic [1:0] KEYS [4] = '{2'b10, 2'b01, 2'b01, 2'b11};

  spdref_top #(.OVS_CYCLES(20)) u_spdref_top (.*);
  spdref_partner u_spdref_partner (.*);

  // ****
  // Helpers
  // ****
  task automatic run(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : run
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask : check
  task automatic wr(input logic [9:0] i, input int d);
    @(posedge sys_clk);
    par_wr <= 1'b1;
    par_index <= i;
    par_wdata <= 16'(d);
    @(posedge sys_clk);
    par_wr <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [9:0] i, input logic [15:0] e);
    @(posedge sys_clk);
    par_index <= i;
    run(2);
    check(par_rdata, e, "readback");
  endtask : rdchk
  task automatic en(input logic v, input int n);
    @(posedge sys_clk);
    drive_enable <= v;
    run(n);
  endtask : en
  function automatic logic [15:0] f_ref(input int v, input int mn, input int mx, input int rt);
    int r;
    r = (v > 18000) ? 18000 : v;
    r = (r < mn) ? mn : r;
    r = (r > mx) ? mx : r;
    r = (r > rt * 34 / 10) ? rt * 34 / 10 : r;
    return 16'(r);
  endfunction : f_ref
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  // ****
  // Main sequence
  // ****
  initial
  begin
    {rstn, par_wr, drive_enable, remote_mode, local_direction_select} = '0;
    {remote_direction_select, inch_command, ext_reference_valid, dc_undervoltage} = '0;
    {nv_restore_valid, fault_reset, key_up_req, key_dn_req, din_req} = '0;
    {par_index, par_wdata, ext_reference, nv_restore_data, set_speed} = '0;
    {local_reference_source_select, remote_reference_source_select} = '0;
    {local_inch_source_select, remote_inch_source_select, input_function_select} = '0;
    motor_rated_speed_setting = 16'd5000;
    void'($urandom(6446));
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rdchk(RI[i], RV[i]);
    wr(10'h3FF, 16'h1234);
    rdchk(10'h3FF, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      kp = (i == 1) ? 65535 : $urandom_range(18000);
      mn = (i == 0) ? 3000 : $urandom_range(18000);
      mx = (i == 0) ? 2000 : $urandom_range(18000);
      wr(`SPDREF_IDX_MIN, mn);
      wr(`SPDREF_IDX_MAX, mx);
      wr(`SPDREF_IDX_KEYPAD, kp);
      en(1'b1, 6);
      check(speed_reference, f_ref(kp, mn, mx, 5000), "clamp");
      en(1'b0, 4);
    end
    wr(`SPDREF_IDX_MIN, 0);
    wr(`SPDREF_IDX_MAX, 1800);
    wr(`SPDREF_IDX_KEYPAD, 500);
    en(1'b1, 6);
    ex = 500;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      {key_up_req, key_dn_req} <= KEYS[i];
      @(posedge sys_clk);
      {key_up_req, key_dn_req} <= 2'b00;
      run(5);
      ex = ex + ((KEYS[i] == 2'b10) ? 1 : (KEYS[i] == 2'b01) ? -1 : 0);
      check(speed_reference, 16'(ex), "keys");
    end
    en(1'b0, 4);
    @(posedge sys_clk);
    motor_rated_speed_setting <= 16'd100;
    wr(`SPDREF_IDX_KEYPAD, 1000);
    en(1'b1, 6);
    check(speed_reference, 16'd340, "rated cap");
    en(1'b0, 4);
    @(posedge sys_clk);
    motor_rated_speed_setting <= 16'd5000;
    wr(`SPDREF_IDX_BACKUP, 0);
    wr(`SPDREF_IDX_MIN, 200);
    for (int s = 0; s < 2; s++)
    begin
      @(posedge sys_clk);
      local_reference_source_select <= 4'(s);
      ext_reference <= 16'd600;
      ext_reference_valid <= 1'b1;
      @(posedge sys_clk);
      ext_reference_valid <= 1'b0;
      wr(`SPDREF_IDX_KEYPAD, 700);
      en(1'b1, 6);
      check(speed_reference, (s == 0) ? 16'd700 : 16'd600, "source");
      en(1'b0, 4);
      en(1'b1, 6);
      check(speed_reference, 16'd200, "no backup");
      en(1'b0, 4);
    end
    @(posedge sys_clk);
    local_reference_source_select <= 4'h0;
    wr(`SPDREF_IDX_BACKUP, 1);
    wr(`SPDREF_IDX_KEYPAD, 1234);
    @(posedge sys_clk);
    dc_undervoltage <= 1'b1;
    k = 0;
    while (nv_write !== 1'b1 && k < 6)
    begin
      run(1);
      k++;
    end
    check({15'h0, nv_write}, 16'h0001, "save strobe");
    check(nv_wdata, 16'd1234, "saved value");
    @(posedge sys_clk);
    dc_undervoltage <= 1'b0;
    nv_restore_data <= 16'd777;
    nv_restore_valid <= 1'b1;
    @(posedge sys_clk);
    nv_restore_valid <= 1'b0;
    rdchk(`SPDREF_IDX_KEYPAD, 16'd777);
    k = $urandom_range(7);
    @(posedge sys_clk);
    input_function_select[k] <= `SPDREF_FN_JOG;
    local_inch_source_select <= `SPDREF_INCH_SRC_DIN;
    local_direction_select <= 1'b1;
    din_req[k] <= 1'b1;
    run(10);
    check({15'h0, jog_active}, 16'h0001, "jog on");
    check({15'h0, reverse_dir}, 16'h0001, "jog dir");
    @(posedge sys_clk);
    din_req[k] <= 1'b0;
    run(10);
    check({15'h0, jog_active}, 16'h0000, "jog off");
    @(posedge sys_clk);
    set_speed <= 16'd50;
    din_req[k] <= 1'b1;
    run(10);
    check({15'h0, jog_active}, 16'h0000, "jog moving");
    @(posedge sys_clk);
    {din_req, set_speed, remote_direction_select} <= '0;
    {remote_mode, inch_command} <= 2'b11;
    run(10);
    check({15'h0, jog_active}, 16'h0001, "remote jog");
    check({15'h0, reverse_dir}, 16'h0000, "remote dir");
    @(posedge sys_clk);
    {remote_mode, inch_command, input_function_select} <= '0;
    run(10);
    wr(`SPDREF_IDX_JOGM, 200);
    wr(`SPDREF_IDX_KEYPAD, 1000);
    @(posedge sys_clk);
    input_function_select[0] <= `SPDREF_FN_JOGP;
    input_function_select[1] <= `SPDREF_FN_JOGM;
    en(1'b1, 6);
    for (int j = 0; j < 2; j++)
    begin
      @(posedge sys_clk);
      din_req[j] <= 1'b1;
      run(10);
      check(speed_reference, (j == 0) ? 16'd1150 : 16'd800, "jog step");
      @(posedge sys_clk);
      din_req[j] <= 1'b0;
      run(10);
      check(speed_reference, 16'd1000, "jog release");
    end
    wr(`SPDREF_IDX_MAX, 1000);
    @(posedge sys_clk);
    set_speed <= 16'd1101;
    run(15);
    @(posedge sys_clk);
    set_speed <= 16'd1100;
    run(40);
    check({15'h0, overspeed_fault}, 16'h0000, "at threshold");
    @(posedge sys_clk);
    set_speed <= 16'd1101;
    run(30);
    check({15'h0, overspeed_fault}, 16'h0001, "trip");
    check({15'h0, pwm_block}, 16'h0001, "pwm block");
    check({8'h0, overspeed_fault_code}, 16'h0096, "fault code");
    @(posedge sys_clk);
    set_speed <= 16'd0;
    run(2);
    @(posedge sys_clk);
    fault_reset <= 1'b1;
    @(posedge sys_clk);
    fault_reset <= 1'b0;
    wr(`SPDREF_IDX_MARGIN, 150);
    rdchk(`SPDREF_IDX_MARGIN, 16'd100);
    check({15'h0, overspeed_fault}, 16'h0000, "fault reset");
    @(posedge sys_clk);
    set_speed <= 16'd5000;
    run(40);
    check({15'h0, overspeed_fault}, 16'h0000, "detect off");
    summarize();
  end
endmodule : testbench

//--- spdref_top.sv
// Speed reference, jog commands, limits and overspeed trip
`timescale 1ns/1ps
`include "spdref_defines.svh"
module spdref_top
  import spdref_pkg::*;
#(
  parameter int OVS_CYCLES = (`SPDREF_OVS_TIME_MS * (`SPDREF_CLK_HZ / 1000)),
  parameter int NUM_DIN    = 8
)(
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  input  wire logic                par_wr,
  input  wire logic [9:0]          par_index,
  input  wire logic [15:0]         par_wdata,
  output logic      [15:0]         par_rdata,
  input  wire logic                drive_enable,
  input  wire logic                remote_mode,
  input  wire logic [3:0]          local_reference_source_select,
  input  wire logic [3:0]          remote_reference_source_select,
  input  wire logic                local_direction_select,
  input  wire logic                remote_direction_select,
  input  wire logic [3:0]          local_inch_source_select,
  input  wire logic [3:0]          remote_inch_source_select,
  input  wire logic                inch_command,
  input  wire logic [NUM_DIN-1:0][4:0] input_function_select,
  input  wire logic [NUM_DIN-1:0]  isolated_digital_input,
  input  wire logic                keypad_up,
  input  wire logic                keypad_down,
  input  wire logic [15:0]         ext_reference,
  input  wire logic                ext_reference_valid,
  input  wire logic [15:0]         motor_rated_speed_setting,
  input  wire logic [15:0]         actual_speed,
  input  wire logic                dc_undervoltage,
  input  wire logic [15:0]         nv_restore_data,
  input  wire logic                nv_restore_valid,
  input  wire logic                fault_reset,
  output logic      [15:0]         speed_reference,
  output logic                     reverse_dir,
  output logic                     jog_active,
  output logic                     pwm_block,
  output logic                     overspeed_fault,
  output logic      [7:0]          overspeed_fault_code,
  output logic                     nv_write,
  output logic      [15:0]         nv_wdata
);

  // ***********************************************
  // Functions
  // ***********************************************
  function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[16] ? 16'hFFFF : s[15:0];
  endfunction : sat_add

  function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
    sat_sub = (a > b) ? (a - b) : 16'h0000;
  endfunction : sat_sub

  function automatic logic [15:0] lim_speed(input logic [15:0] v);
    lim_speed = (v > `SPDREF_SPEED_MAX) ? `SPDREF_SPEED_MAX : v;
  endfunction : lim_speed

  function automatic logic any_fn(input logic [NUM_DIN-1:0][4:0] fsel,
                                  input logic [NUM_DIN-1:0] din,
                                  input logic [4:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_DIN; i++)
      hit = hit | (din[i] && (fsel[i] == code));
    any_fn = hit;
  endfunction : any_fn

  // ***********************************************
  // Parameter storage
  // ***********************************************
  spdref_speed_t reference_backup_enable;
  spdref_speed_t keypad_speed_reference;
  spdref_speed_t jog_plus_speed_value;
  spdref_speed_t jog_minus_speed_value;
  spdref_speed_t overspeed_margin_percent;
  spdref_speed_t minimum_speed_limit;
  spdref_speed_t maximum_speed_limit;
  spdref_speed_t held_ext_reference;
  spdref_state_t state;
  spdref_state_t next_state;

  logic [NUM_DIN-1:0] din_s1;
  logic [NUM_DIN-1:0] din_s2;
  logic [NUM_DIN-1:0] din_s3;
  logic [NUM_DIN-1:0] din_q;
  logic               enable_q;
  logic               uv_q;

  spdref_ovs_if ovs_bus ();

  // ***********************************************
  // Decoding
  // ***********************************************
  wire wr_backup = par_wr && (par_index == `SPDREF_IDX_BACKUP);
  wire wr_keypad = par_wr && (par_index == `SPDREF_IDX_KEYPAD);
  wire wr_jogp   = par_wr && (par_index == `SPDREF_IDX_JOGP);
  wire wr_jogm   = par_wr && (par_index == `SPDREF_IDX_JOGM);
  wire wr_margin = par_wr && (par_index == `SPDREF_IDX_MARGIN);
  wire wr_min    = par_wr && (par_index == `SPDREF_IDX_MIN);
  wire wr_max    = par_wr && (par_index == `SPDREF_IDX_MAX);

  wire        backup_on    = reference_backup_enable[0];
  wire        disable_edge = enable_q && !drive_enable;
  wire        uv_edge      = dc_undervoltage && !uv_q;
  wire [3:0]  ref_src      = remote_mode ? remote_reference_source_select
                                         : local_reference_source_select;
  wire [3:0]  inch_src     = remote_mode ? remote_inch_source_select
                                         : local_inch_source_select;
  wire        dir_sel      = remote_mode ? remote_direction_select
                                         : local_direction_select;
  wire        src_keypad   = (ref_src == `SPDREF_SRC_KEYPAD);
  wire        jog_cmd      = (inch_src == `SPDREF_INCH_SRC_DIN)
                             ? any_fn(input_function_select, din_q, `SPDREF_FN_JOG)
                             : inch_command;
  wire        jogp_cmd     = any_fn(input_function_select, din_q, `SPDREF_FN_JOGP);
  wire        jogm_cmd     = any_fn(input_function_select, din_q, `SPDREF_FN_JOGM);
  wire        motor_stop   = (actual_speed == 16'h0000);

  // ***********************************************
  // Drive state
  // ***********************************************
  always_comb
  begin
    next_state = state;
    case (state)
      SPDREF_IDLE:
        if (jog_cmd && motor_stop)
          next_state = SPDREF_JOG;
        else if (drive_enable)
          next_state = SPDREF_RUN;
      SPDREF_RUN:
        if (!drive_enable)
          next_state = SPDREF_IDLE;
      SPDREF_JOG:
        if (!jog_cmd)
          next_state = SPDREF_IDLE;
      default:
        next_state = SPDREF_IDLE;
    endcase
  end

  // ***********************************************
  // Reference selection and limits
  // ***********************************************
  wire [15:0] base_ref  = src_keypad ? keypad_speed_reference : held_ext_reference;
  wire [15:0] jog_total = jogp_cmd ? sat_add(base_ref, jog_plus_speed_value)
                        : jogm_cmd ? sat_sub(base_ref, jog_minus_speed_value)
                        : base_ref;
  wire [15:0] raw_ref   = (state == SPDREF_JOG) ? jog_plus_speed_value : jog_total;
  wire [21:0] cap_prod  = motor_rated_speed_setting * `SPDREF_CAP_NUM;
  wire [21:0] cap_div   = cap_prod / 22'(`SPDREF_CAP_DEN);
  wire [15:0] cap_speed = (cap_div > 22'h00FFFF) ? 16'hFFFF : cap_div[15:0];
  wire [15:0] hi_lim    = (maximum_speed_limit > cap_speed) ? cap_speed
                                                            : maximum_speed_limit;
  wire [15:0] lo_ref    = (raw_ref < minimum_speed_limit) ? minimum_speed_limit : raw_ref;
  wire [15:0] clamp_ref = (lo_ref > hi_lim) ? hi_lim : lo_ref;
  wire        run_state = (state != SPDREF_IDLE);
  wire [15:0] next_ref  = (run_state && !overspeed_fault) ? clamp_ref : 16'h0000;

  // ***********************************************
  // Overspeed threshold
  // ***********************************************
  wire [31:0] margin_prod = maximum_speed_limit * overspeed_margin_percent;
  wire [31:0] margin_div  = margin_prod / 32'd100;
  wire [17:0] ovs_thresh  = 18'({2'b00, maximum_speed_limit}) + margin_div[17:0];

  assign ovs_bus.threshold    = ovs_thresh;
  assign ovs_bus.detect_en    = (overspeed_margin_percent < `SPDREF_MARGIN_OFF);
  assign ovs_bus.actual_speed = actual_speed;

  spdref_ovs #(
    .OVS_CYCLES (OVS_CYCLES)
  ) u_ovs (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .ovs     (ovs_bus)
  );

  // ***********************************************
  // Readback
  // ***********************************************
  wire [15:0] status_word = {11'h000, pwm_block, overspeed_fault, jog_active,
                             run_state, backup_on};
  wire [15:0] next_rdata =
      (par_index == `SPDREF_IDX_BACKUP)  ? reference_backup_enable  :
      (par_index == `SPDREF_IDX_KEYPAD)  ? keypad_speed_reference   :
      (par_index == `SPDREF_IDX_JOGP)    ? jog_plus_speed_value     :
      (par_index == `SPDREF_IDX_JOGM)    ? jog_minus_speed_value    :
      (par_index == `SPDREF_IDX_MARGIN)  ? overspeed_margin_percent :
      (par_index == `SPDREF_IDX_MIN)     ? minimum_speed_limit      :
      (par_index == `SPDREF_IDX_MAX)     ? maximum_speed_limit      :
      (par_index == `SPDREF_IDX_STATUS)  ? status_word              :
      (par_index == `SPDREF_IDX_REF_OUT) ? speed_reference          : 16'h0000;

  // ***********************************************
  // Input synchronisers
  // ***********************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      din_s1 <= '0;
      din_s2 <= '0;
      din_s3 <= '0;
      din_q  <= '0;
    end
    else
    begin
      din_s1 <= isolated_digital_input;
      din_s2 <= din_s1;
      din_s3 <= din_s2;
      for (int i = 0; i < NUM_DIN; i++)
        if (din_s2[i] == din_s3[i])
          din_q[i] <= din_s3[i];
    end
  end

  // ***********************************************
  // Configuration parameters
  // ***********************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      reference_backup_enable  <= `SPDREF_RST_BACKUP;
      jog_plus_speed_value     <= `SPDREF_RST_JOGP;
      jog_minus_speed_value    <= `SPDREF_RST_JOGM;
      overspeed_margin_percent <= `SPDREF_RST_MARGIN;
      minimum_speed_limit      <= `SPDREF_RST_MIN;
      maximum_speed_limit      <= `SPDREF_RST_MAX;
    end
    else
    begin
      if (wr_backup)
        reference_backup_enable <= {15'h0000, par_wdata[0]};
      if (wr_jogp)
        jog_plus_speed_value <= lim_speed(par_wdata);
      if (wr_jogm)
        jog_minus_speed_value <= lim_speed(par_wdata);
      if (wr_margin)
        overspeed_margin_percent <= (par_wdata > `SPDREF_MARGIN_OFF) ? `SPDREF_MARGIN_OFF
                                                                    : par_wdata;
      if (wr_min)
        minimum_speed_limit <= lim_speed(par_wdata);
      if (wr_max)
        maximum_speed_limit <= lim_speed(par_wdata);
    end
  end

  // ***********************************************
  // Keypad and external references with backup
  // ***********************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      keypad_speed_reference <= `SPDREF_RST_KEYPAD;
      held_ext_reference     <= '0;
    end
    else if (disable_edge && !backup_on)
    begin
      keypad_speed_reference <= minimum_speed_limit;
      held_ext_reference     <= minimum_speed_limit;
    end
    else
    begin
      if (wr_keypad)
        keypad_speed_reference <= lim_speed(par_wdata);
      else if (nv_restore_valid && backup_on)
        keypad_speed_reference <= lim_speed(nv_restore_data);
      else if (src_keypad && keypad_up && !keypad_down)
        keypad_speed_reference <= lim_speed(sat_add(keypad_speed_reference, 16'h0001));
      else if (src_keypad && keypad_down && !keypad_up)
        keypad_speed_reference <= sat_sub(keypad_speed_reference, 16'h0001);
      if (ext_reference_valid && !src_keypad)
        held_ext_reference <= lim_speed(ext_reference);
    end
  end

  // ***********************************************
  // Nonvolatile save on undervoltage
  // ***********************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      uv_q     <= 1'b0;
      nv_write <= 1'b0;
      nv_wdata <= '0;
    end
    else
    begin
      uv_q     <= dc_undervoltage;
      nv_write <= uv_edge && backup_on;
      if (uv_edge && backup_on)
        nv_wdata <= keypad_speed_reference;
    end
  end

  // ***********************************************
  // Drive outputs
  // ***********************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state           <= SPDREF_IDLE;
      enable_q        <= 1'b0;
      speed_reference <= '0;
      reverse_dir     <= 1'b0;
      jog_active      <= 1'b0;
      par_rdata       <= '0;
    end
    else
    begin
      state           <= next_state;
      enable_q        <= drive_enable;
      speed_reference <= next_ref;
      reverse_dir     <= dir_sel;
      jog_active      <= (next_state == SPDREF_JOG);
      par_rdata       <= next_rdata;
    end
  end

  // ***********************************************
  // Overspeed fault
  // ***********************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      overspeed_fault      <= 1'b0;
      pwm_block            <= 1'b0;
      overspeed_fault_code <= 8'h00;
    end
    else if (ovs_bus.over_trip)
    begin
      overspeed_fault      <= 1'b1;
      pwm_block            <= 1'b1;
      overspeed_fault_code <= `SPDREF_FAULT_CODE;
    end
    else if (fault_reset)
    begin
      overspeed_fault      <= 1'b0;
      pwm_block            <= 1'b0;
      overspeed_fault_code <= 8'h00;
    end
  end

endmodule : spdref_top
